// file: hdl/pfa_consts.svh
// Offsets, field positions, reset values and timing counts of the flash access block
`ifndef PFA_CONSTS_SVH
`define PFA_CONSTS_SVH
`define PFA_FLASH_CONTROL_STATUS_ADDR 8'h2F
`define PFA_STAT_ADDR 8'h7F
`define PFA_FLASH_CONTROL_STATUS_RESET 8'h00
`define PFA_KEY1 8'h56
`define PFA_KEY2 8'hAE
`define PFA_BIT_OPT 2
`define PFA_BIT_LAT 1
`define PFA_BIT_PGM 0
`define PFA_OPTB_READLOCK 0
`define PFA_OPTB_WRITELOCK 1
`define PFA_BUF_BYTES 32
`define PFA_ROW_W 6
`define PFA_FADDR_W 11
`define PFA_RAM_AW 7
`define PFA_CLK_PERIOD_NS 4
`define PFA_PROG_TIME_NS 4000
`define PFA_PROG_CYCLES ((`PFA_PROG_TIME_NS + `PFA_CLK_PERIOD_NS - 1) / `PFA_CLK_PERIOD_NS)
`define PFA_WAIT_W 12
`endif

// file: hdl/pfa_flash_access.sv
// Program flash sequencer, protection and serial programming entry
// Operation
// - Program one byte or up to 32 together
// - Sector erase leaves other sectors untouched
// - External modes may alter sectors, options, EEPROM
// - Self-programming keeps sector 0 protected
// - Serial entry selects system memory reset vector
// - Bytes download to RAM, then run
// - Read lock and write lock independent
// - Read lock blocks external memory extraction
// - Read lock follows its option bit
// - Clearing read lock erases everything first
// - Write lock refuses program memory changes other than mass erase
// - Write lock can never be cleared
// - Keys 56h then AEh unlock register
// - Register resets 00h, upper bits zero
`timescale 1ns/1ns
`default_nettype none
module pfa_flash_access
  import pfa_pkg::*;
#(
  parameter logic [`PFA_FADDR_W-1:0] SECTOR0_END = 11'h400,
  parameter logic [7:0] ENTRY_PATTERN = 8'hA5,
  parameter logic [`PFA_RAM_AW:0] DRIVER_LEN = 8'h40
) (
  // System clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Flash data writes from the core
  input wire logic I_FL_WR,
  input wire logic [`PFA_FADDR_W-1:0] I_FL_ADDR,
  input wire logic [7:0] I_FL_DATA,
  // Mode and option bits
  input wire logic I_SELF_PROG,
  input wire logic I_READLOCK,
  input wire logic I_WRITELOCK,
  // Programming link pins
  input wire logic I_LINK_CLK,
  input wire logic I_LINK_DATA,
  input wire logic I_RST_PIN_N,
  // Flash array command
  output pfa_arr_t O_ARR,
  output logic O_MASS_ERASE,
  // Boot control and RAM download
  output logic O_SYSMEM_VECTOR,
  output logic O_RUN_FROM_RAM,
  output pfa_ram_t O_RAM,
  // Protection status
  output logic O_EXT_READ_BLOCK,
  output logic O_EE_WR_EN
);
  import pfa_pkg::*;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
    reg_hit = (a == r);
  endfunction

  // Whether the current mode may alter the target area
  function automatic logic may_alter(input logic opt_row, input logic sec0,
                                     input logic selfp, input logic wlock);
    if (opt_row) begin
      may_alter = !selfp;
    end else begin
      may_alter = !wlock && !(selfp && sec0);
    end
  endfunction

  // Link domain, runs only while the tool clocks it
  pfa_link_t lk;
  pfa_link_t next_lk;

  always_comb begin
    next_lk = lk;
    next_lk.rst_s1 = I_RST_N;
    next_lk.rst_s2 = lk.rst_s1;
    next_lk.pin_s1 = I_RST_PIN_N;
    next_lk.pin_s2 = lk.pin_s1;
    if (!lk.rst_s2) begin
      next_lk.entry_sh = 8'h00;
      next_lk.armed = 1'b0;
      next_lk.bit_cnt = 3'h0;
      // Toggle must start known, or no byte ever crosses
      next_lk.toggle = 1'b0;
      next_lk.byte_sh = 8'h00;
      next_lk.byte_hold = 8'h00;
    end else if (!lk.pin_s2) begin
      next_lk.entry_sh = {lk.entry_sh[6:0], I_LINK_DATA};
      next_lk.armed = ({lk.entry_sh[6:0], I_LINK_DATA} == ENTRY_PATTERN);
      next_lk.bit_cnt = 3'h0;
    end else if (lk.armed) begin
      next_lk.byte_sh = {lk.byte_sh[6:0], I_LINK_DATA};
      next_lk.bit_cnt = lk.bit_cnt + 3'h1;
      if (lk.bit_cnt == 3'h7) begin
        next_lk.byte_hold = {lk.byte_sh[6:0], I_LINK_DATA};
        next_lk.toggle = !lk.toggle;
      end
    end
  end

  always_ff @(posedge I_LINK_CLK) begin
    lk <= next_lk;
  end

  // System domain
  pfa_sys_t st;
  pfa_sys_t next_st;
  logic [7:0] flash_control_status;
  logic [7:0] stat;
  logic busy;
  logic start_ok;
  logic any_vld;

  assign flash_control_status = {5'h00, st.option_row_select, st.lat, st.program_start};
  assign stat = {4'h0, st.denied, st.serial_mode, busy, st.key == PFA_OPEN};
  assign busy = (st.fsm != PFA_IDLE);
  assign any_vld = |st.buf_vld;
  assign start_ok = may_alter(st.option_row_select, {st.row, 5'h00} < SECTOR0_END, I_SELF_PROG,
                              I_WRITELOCK);

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.arr.we = 1'b0;
    next_st.arr.erase = 1'b0;
    next_st.mass_erase = 1'b0;
    next_st.ram.we = 1'b0;
    // Crossings from the link domain
    next_st.pin_s1 = I_RST_PIN_N;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    next_st.arm_s1 = lk.armed;
    next_st.arm_s2 = st.arm_s1;
    next_st.tog_s1 = lk.toggle;
    next_st.tog_s2 = st.tog_s1;
    next_st.tog_prev = st.tog_s2;
    // Entry latched as the tool releases reset
    if (st.pin_s2 && !st.pin_prev) begin
      next_st.serial_mode = st.arm_s2;
      next_st.run_ram = 1'b0;
      next_st.ram.addr = '0;
    end else if (!st.pin_s2) begin
      next_st.serial_mode = 1'b0;
    end
    // Byte is stable in the link holder for eight link clocks after the toggle
    if (st.serial_mode && !st.run_ram && (st.tog_s2 != st.tog_prev)) begin
      next_st.ram.we = 1'b1;
      next_st.ram.data = lk.byte_hold;
      next_st.ram.addr = st.ram.addr;
    end
    // Run flag follows the last write, so that write still counts as download
    if (st.ram.we) begin
      next_st.ram.addr = st.ram.addr + 7'h01;
      if ({1'b0, st.ram.addr} == DRIVER_LEN - 8'h01) begin
        next_st.run_ram = 1'b1;
      end
    end
    next_st.ext_block = I_READLOCK && st.serial_mode;
    next_st.ee_wr_en = !(I_READLOCK && st.serial_mode);
    // Register reads
    if (I_RD) begin
      if (reg_hit(I_ADDR, `PFA_FLASH_CONTROL_STATUS_ADDR)) begin
        next_st.rdata = flash_control_status;
      end else if (reg_hit(I_ADDR, `PFA_STAT_ADDR)) begin
        next_st.rdata = stat;
      end
    end
    // Key sequence and guarded register writes
    if (I_WR && reg_hit(I_ADDR, `PFA_FLASH_CONTROL_STATUS_ADDR)) begin
      case (st.key)
        PFA_LOCKED: begin
          next_st.key = (I_WDATA == `PFA_KEY1) ? PFA_KEYED : PFA_LOCKED;
        end
        PFA_KEYED: begin
          next_st.key = (I_WDATA == `PFA_KEY2) ? PFA_OPEN : PFA_LOCKED;
        end
        PFA_OPEN: begin
          next_st.key = PFA_LOCKED;
          if (!busy) begin
            next_st.option_row_select = I_WDATA[`PFA_BIT_OPT];
            next_st.lat = I_WDATA[`PFA_BIT_LAT];
            next_st.program_start = I_WDATA[`PFA_BIT_PGM];
          end
        end
        default: begin
          next_st.key = PFA_LOCKED;
        end
      endcase
    end
    // Data latches, one byte or a whole 32-byte row
    if (I_FL_WR && st.lat && !busy && !st.program_start) begin
      next_st.buf_data[I_FL_ADDR[4:0]] = I_FL_DATA;
      next_st.buf_vld[I_FL_ADDR[4:0]] = 1'b1;
      next_st.row = I_FL_ADDR[`PFA_FADDR_W-1:5];
    end
    if (!st.lat) begin
      next_st.buf_vld = '0;
    end
    case (st.fsm)
      PFA_IDLE: begin
        if (st.program_start) begin
          if (!start_ok) begin
            next_st.denied = 1'b1;
            next_st.program_start = 1'b0;
            next_st.lat = 1'b0;
            next_st.buf_vld = '0;
          end else if (any_vld) begin
            next_st.denied = 1'b0;
            next_st.idx = 5'h00;
            next_st.fsm = PFA_PROG;
            // Removing read lock wipes program memory and EEPROM first
            if (st.option_row_select && I_READLOCK && st.buf_vld[0] &&
                !st.buf_data[0][`PFA_OPTB_READLOCK]) begin
              next_st.mass_erase = 1'b1;
            end
          end else begin
            next_st.denied = 1'b0;
            next_st.arr.erase = !st.option_row_select;
            next_st.arr.option_row_select = st.option_row_select;
            next_st.arr.addr = {st.row, 5'h00};
            next_st.arr.data = 8'h00;
            next_st.wait_cnt = '0;
            next_st.fsm = PFA_WAIT;
          end
        end
      end
      PFA_PROG: begin
        next_st.arr.we = st.buf_vld[st.idx];
        next_st.arr.option_row_select = st.option_row_select;
        next_st.arr.addr = {st.row, st.idx};
        next_st.arr.data = st.buf_data[st.idx];
        if (st.option_row_select && st.idx == 5'h00 && I_WRITELOCK) begin
          next_st.arr.data[`PFA_OPTB_WRITELOCK] = 1'b1;
        end
        next_st.idx = st.idx + 5'h01;
        if (st.idx == 5'h1F) begin
          next_st.wait_cnt = '0;
          next_st.fsm = PFA_WAIT;
        end
      end
      PFA_WAIT: begin
        next_st.wait_cnt = st.wait_cnt + 12'h001;
        if (st.wait_cnt == 12'(`PFA_PROG_CYCLES - 1)) begin
          next_st.program_start = 1'b0;
          next_st.lat = 1'b0;
          next_st.buf_vld = '0;
          next_st.fsm = PFA_IDLE;
        end
      end
      default: begin
        next_st.fsm = PFA_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st <= '0;
      st.fsm <= PFA_IDLE;
      st.key <= PFA_LOCKED;
      st.pin_s1 <= 1'b1;
      st.pin_s2 <= 1'b1;
      st.pin_prev <= 1'b1;
      st.ee_wr_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA = st.rdata;
  assign O_ARR = st.arr;
  assign O_MASS_ERASE = st.mass_erase;
  assign O_SYSMEM_VECTOR = st.serial_mode;
  assign O_RUN_FROM_RAM = st.run_ram;
  assign O_RAM = st.ram;
  assign O_EXT_READ_BLOCK = st.ext_block;
  assign O_EE_WR_EN = st.ee_wr_en;

  property p_locked_write;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_WR && reg_hit(I_ADDR, `PFA_FLASH_CONTROL_STATUS_ADDR) && st.key != PFA_OPEN) |=> $stable(flash_control_status);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write changed reg");

  property p_key_open;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_WR && reg_hit(I_ADDR, `PFA_FLASH_CONTROL_STATUS_ADDR) && I_WDATA == `PFA_KEY1 && st.key == PFA_LOCKED)
    ##1 (I_WR && reg_hit(I_ADDR, `PFA_FLASH_CONTROL_STATUS_ADDR) && I_WDATA == `PFA_KEY2) |=> st.key == PFA_OPEN;
  endproperty
  a_key_open: assert property (p_key_open) else $error("key pair did not unlock");

  property p_rdata_upper;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_RD && reg_hit(I_ADDR, `PFA_FLASH_CONTROL_STATUS_ADDR)) |=> O_RDATA[7:3] == 5'h00 && O_RDATA[2:0] == $past(flash_control_status[2:0]);
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("reg read data wrong");

  property p_iap_sec0;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_SELF_PROG && O_ARR.we) |-> (!O_ARR.option_row_select && O_ARR.addr >= SECTOR0_END);
  endproperty
  a_iap_sec0: assert property (p_iap_sec0) else $error("self-programming hit protected area");

  property p_wlock_prog;
    @(posedge I_CLK) disable iff (!I_RST_N)
    $stable(I_WRITELOCK) && I_WRITELOCK && (O_ARR.we || O_ARR.erase) |-> O_ARR.option_row_select && !O_ARR.erase;
  endproperty
  a_wlock_prog: assert property (p_wlock_prog) else $error("program memory altered under lock");

  property p_wlock_keep;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (O_ARR.we && O_ARR.option_row_select && O_ARR.addr[4:0] == 5'h00 && $past(I_WRITELOCK, 2))
    |-> O_ARR.data[`PFA_OPTB_WRITELOCK];
  endproperty
  a_wlock_keep: assert property (p_wlock_keep) else $error("write lock bit cleared");

  property p_mass_erase;
    @(posedge I_CLK) disable iff (!I_RST_N)
    O_MASS_ERASE |-> $past(st.option_row_select) && $past(I_READLOCK) && $past(st.fsm) == PFA_IDLE ##1 st.fsm == PFA_PROG;
  endproperty
  a_mass_erase: assert property (p_mass_erase) else $error("mass erase without lock removal");

  property p_ext_block;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_READLOCK && st.serial_mode) |=> O_EXT_READ_BLOCK || !$past(I_READLOCK);
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("read lock not blocking");

  property p_ram_load;
    @(posedge I_CLK) disable iff (!I_RST_N)
    O_RAM.we |-> O_SYSMEM_VECTOR && !O_RUN_FROM_RAM ##1 !O_RAM.we;
  endproperty
  a_ram_load: assert property (p_ram_load) else $error("RAM load outside download");
endmodule
`default_nettype wire

// file: hdl/pfa_pkg.sv
// Types of the flash access block
`include "pfa_consts.svh"
package pfa_pkg;
  typedef enum logic [2:0] {
    PFA_IDLE = 3'b001,
    PFA_PROG = 3'b010,
    PFA_WAIT = 3'b100
  } pfa_fsm_t;
  typedef enum logic [2:0] {
    PFA_LOCKED = 3'b001,
    PFA_KEYED = 3'b010,
    PFA_OPEN = 3'b100
  } pfa_key_t;
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic pin_s1;
    logic pin_s2;
    logic [7:0] entry_sh;
    logic armed;
    logic [2:0] bit_cnt;
    logic [7:0] byte_sh;
    logic [7:0] byte_hold;
    logic toggle;
  } pfa_link_t;
  typedef struct packed {
    logic we;
    logic erase;
    logic option_row_select;
    logic [`PFA_FADDR_W-1:0] addr;
    logic [7:0] data;
  } pfa_arr_t;
  typedef struct packed {
    logic we;
    logic [`PFA_RAM_AW-1:0] addr;
    logic [7:0] data;
  } pfa_ram_t;
  typedef struct packed {
    pfa_fsm_t fsm;
    pfa_key_t key;
    logic option_row_select;
    logic lat;
    logic program_start;
    logic denied;
    logic [7:0] rdata;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic arm_s1;
    logic arm_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_prev;
    logic serial_mode;
    logic run_ram;
    pfa_ram_t ram;
    logic [`PFA_BUF_BYTES-1:0][7:0] buf_data;
    logic [`PFA_BUF_BYTES-1:0] buf_vld;
    logic [`PFA_ROW_W-1:0] row;
    logic [4:0] idx;
    logic [`PFA_WAIT_W-1:0] wait_cnt;
    pfa_arr_t arr;
    logic mass_erase;
    logic ext_block;
    logic ee_wr_en;
  } pfa_sys_t;
endpackage

// file: sim/pfa_tool.sv
// Programming tool model driving the link pins
`timescale 1ns/1ns
`default_nettype none
module pfa_tool (
  // Link pins
  output logic o_clk,
  output logic o_data,
  output logic o_rst_n
);
  initial begin
    // Pull-up keeps the clock high between frames
    o_clk = 1'b1;
    o_data = 1'b0;
    o_rst_n = 1'b1;
  end
  // One byte, MSB first, data changed while the clock is low
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_clk = 1'b0;
      o_data = b[i];
      #62;
      o_clk = 1'b1;
      #63;
    end
    // Released line must not keep showing the last bit
    o_data = ~b[0];
  endtask
  // One link clock carrying a single bit
  task automatic pulse(input logic b);
    o_clk = 1'b0;
    o_data = b;
    #62;
    o_clk = 1'b1;
    #63;
  endtask
  task automatic enter(input logic [7:0] pat);
    o_rst_n = 1'b0;
    #500;
    // Pin level reaches the link side two clocks late, so the pattern goes twice
    send(pat);
    send(pat);
    #500;
    o_rst_n = 1'b1;
    #500;
    // Two clocks carry the release; the pattern must survive a shift by two
    pulse(pat[7]);
    pulse(pat[6]);
  endtask
  task automatic leave();
    o_rst_n = 1'b0;
    #500;
    // Clocked idle bits under reset disarm the entry detector
    send(8'h00);
    o_rst_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench of the flash access block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pfa_pkg::*;
  localparam logic [7:0] DLEN = 8'h04;
  // Period of two bits, so the release clocks keep it whole
  localparam logic [7:0] PAT = 8'h55;
  localparam logic [7:0] F = `PFA_FLASH_CONTROL_STATUS_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fl_wr = 1'b0;
  logic self_prog = 1'b0;
  logic rlock = 1'b0;
  logic wlock = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] fl_data = 8'h00;
  logic [10:0] fl_addr = 11'h000;
  logic [7:0] rdata;
  wire lclk;
  wire ldata;
  wire lrst_n;
  pfa_arr_t arr;
  pfa_ram_t ram;
  logic mass, sysv, runram, xblk, eewr;
  logic rd_d = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  int mass_n = 0;
  logic [7:0] rd_q[$];
  logic [21:0] arr_q[$];
  logic [14:0] ram_q[$];

  always #2 clk = ~clk;

  pfa_tool tool (.o_clk(lclk), .o_data(ldata), .o_rst_n(lrst_n));
  pfa_flash_access #(.SECTOR0_END(11'h400), .ENTRY_PATTERN(PAT), .DRIVER_LEN(DLEN)) dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_FL_WR(fl_wr), .I_FL_ADDR(fl_addr), .I_FL_DATA(fl_data),
    .I_SELF_PROG(self_prog), .I_READLOCK(rlock), .I_WRITELOCK(wlock), .I_LINK_CLK(lclk),
    .I_LINK_DATA(ldata), .I_RST_PIN_N(lrst_n), .O_ARR(arr), .O_MASS_ERASE(mass),
    .O_SYSMEM_VECTOR(sysv), .O_RUN_FROM_RAM(runram), .O_RAM(ram),
    .O_EXT_READ_BLOCK(xblk), .O_EE_WR_EN(eewr));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watcher: every result takes the oldest note; an unexpected one meets x
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) check("rdata", rdata, rd_q.size() ? rd_q.pop_front() : 'x);
    if (arr.we || arr.erase) check("array", arr, arr_q.size() ? arr_q.pop_front() : 'x);
    if (ram.we) check("ram", {ram.addr, ram.data}, ram_q.size() ? ram_q.pop_front() : 'x);
    if (mass) mass_n++;
  end

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
  endtask
  // Keys are spent by each control write, so every write carries its own pair
  task automatic ctl(input logic [7:0] d);
    bus(1'b1, 1'b0, F, `PFA_KEY1);
    bus(1'b1, 1'b0, F, `PFA_KEY2);
    bus(1'b1, 1'b0, F, d);
    bus(1'b0, 1'b0, F, 8'h00);
  endtask
  task automatic flw(input logic [10:0] a, input logic [7:0] d);
    fl_wr <= 1'b1;
    fl_addr <= a;
    fl_data <= d;
    @(posedge clk);
    fl_wr <= 1'b0;
    @(posedge clk);
  endtask
  // n bytes into one row, or an erase when n is 0; ok says whether the array may move
  task automatic prog(input logic [5:0] row, input int n, input logic ok, input logic option_row_select);
    logic [7:0] d;
    ctl({5'h00, option_row_select, 2'b10});
    for (int i = 0; i < n; i++) begin
      d = option_row_select ? 8'h00 : 8'($urandom);
      flw({row, 5'(i)}, d);
      if (ok) arr_q.push_back({2'b10, option_row_select, row, 5'(i), d});
    end
    if (ok && n == 0) arr_q.push_back({3'b010, row, 13'h0000});
    ctl({5'h00, option_row_select, 2'b11});
    repeat (1100) @(posedge clk);
    rreg(F, {5'h00, option_row_select, 2'b00});
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial begin
    logic [7:0] b;
    void'($urandom(17931));
    // Link logic only clears while its clock runs under reset
    tool.send(8'hFF);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(F, 8'h00);
    check("ee_wr_en", eewr, 1'b1);
    done("reset");
    bus(1'b1, 1'b0, F, `PFA_KEY1);
    bus(1'b1, 1'b0, F, 8'h12);
    bus(1'b1, 1'b0, F, 8'h02);
    bus(1'b1, 1'b0, F, 8'h02);
    rreg(F, 8'h00);
    ctl(8'hFA);
    rreg(F, 8'h02);
    ctl(8'h00);
    rreg(F, 8'h00);
    done("keys");
    prog(6'h21, 32, 1'b1, 1'b0);
    prog(6'h30, 1, 1'b1, 1'b0);
    prog(6'h30, 0, 1'b1, 1'b0);
    prog(6'h01, 2, 1'b1, 1'b0);
    done("program");
    self_prog <= 1'b1;
    prog(6'h01, 2, 1'b0, 1'b0);
    prog(6'h22, 1, 1'b1, 1'b0);
    self_prog <= 1'b0;
    wlock <= 1'b1;
    prog(6'h22, 2, 1'b0, 1'b0);
    prog(6'h22, 0, 1'b0, 1'b0);
    wlock <= 1'b0;
    done("protect");
    rlock <= 1'b1;
    prog(6'h00, 1, 1'b1, 1'b1);
    check("mass_erase", mass_n, 1);
    done("unlock erase");
    tool.enter(PAT);
    repeat (20) @(posedge clk);
    check("sysmem", sysv, 1'b1);
    check("ext_block", xblk, 1'b1);
    check("ee_wr_en", eewr, 1'b0);
    for (int i = 0; i < DLEN; i++) begin
      b = 8'($urandom);
      ram_q.push_back({7'(i), b});
      tool.send(b);
    end
    repeat (20) @(posedge clk);
    check("run_ram", runram, 1'b1);
    tool.leave();
    repeat (20) @(posedge clk);
    check("sysmem_off", sysv, 1'b0);
    check("queues", rd_q.size() + arr_q.size() + ram_q.size(), 0);
    done("link");
    wrap_up();
  end
endmodule
`default_nettype wire
